// file: can_rx_length_control_field_bench.sv
// Self-checking bench for the receive length/control status byte.
// Assumes a Wishbone slave that acks one cycle after taking a request.
`timescale 1ns/100ps
module can_rx_length_control_field_bench;
  import rx_len_pkg::*;
  logic        clk, rst, cyc, stb, we, fl;
  logic [7:0]  adr;
  logic [31:0] wd, rd;
  ctrl_field_s fc;
  logic [31:0] dat_o;
  logic        ack, pv;
  logic [3:0]  pb;
  int          err_total, checks_done;
  can_rx_length_control_field u_can_rx_length_control_field (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .frame_load(fl), .frame_ctrl(fc),
    .payload_valid(pv), .payload_bytes(pb));
  // Free-running 50 MHz clock
  always #10 clk = ~clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask : chk
  // One classic cycle; release only after the edge that samples ack
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    // ack and read data are taken at the rising edge that sees ack high
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : xfer
  task load(input logic r, input logic [3:0] c);
    @(posedge clk);
    fl <= 1'b1; fc <= '{r, c};
    @(posedge clk);
    fl <= 1'b0;
    @(negedge clk);
  endtask : load
  task t_reset;
    xfer(1'b0, LEN_CTRL_OFFSET, 32'h0);
    chk("reset byte", {24'h0, LEN_CTRL_RESET}, rd);
  endtask : t_reset
  // Every code 0..15 with the remote flag toggling
  task t_codes;
    logic [3:0] c;
    logic       r, v;
    for (int i = 0; i < 16; i++) begin
      c = i[3:0]; r = i[0]; v = (c <= LEN_MAX);
      load(r, c);
      chk("valid", {31'h0, v}, {31'h0, pv});
      chk("bytes", {28'h0, v ? c : 4'h0}, {28'h0, pb});
      xfer(1'b0, LEN_CTRL_OFFSET, 32'h0);
      chk("byte", {24'h0, 1'b0, r, 2'b00, c}, rd);
      xfer(1'b0, STATUS_OFFSET, 32'h0);
      chk("status", {27'h0, v, v ? c : 4'h0}, rd);
    end
  endtask : t_codes
  // Writes have no effect; unmapped reads give zero
  task t_write;
    load(1'b1, 4'h3);
    xfer(1'b1, LEN_CTRL_OFFSET, 32'hFFFF_FFFF);
    chk("write data", UNMAPPED_DATA, rd);
    xfer(1'b0, LEN_CTRL_OFFSET, 32'h0);
    chk("after write", 32'h0000_0043, rd);
    xfer(1'b0, 8'h08, 32'h0);
    chk("unmapped", UNMAPPED_DATA, rd);
  endtask : t_write
  // Reset in mid-run clears the stored fields and the decoded length
  task t_mid_reset;
    load(1'b1, 4'h5);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset valid", 32'h0, {31'h0, pv});
    chk("reset bytes", 32'h0, {28'h0, pb});
    xfer(1'b0, LEN_CTRL_OFFSET, 32'h0);
    chk("reset byte", {24'h0, LEN_CTRL_RESET}, rd);
  endtask : t_mid_reset
  task tally_and_finish;
    if (err_total == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; fl = 0;
    adr = 8'h00; wd = 32'h0; fc = '0; err_total = 0; checks_done = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_codes;
    t_write;
    t_mid_reset;
    tally_and_finish;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    tally_and_finish;
  end
endmodule : can_rx_length_control_field_bench

// file: rx_len_ctrl.sv
// Receive length/control status byte with a Wishbone read port.
// Assumes the protocol engine pulses frame_load on one clk for each
// accepted frame, with the control field stable in that cycle.
//
// The implementer's own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module can_rx_length_control_field
  import rx_len_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        frame_load,
  input  ctrl_field_s      frame_ctrl,
  output logic             payload_valid,
  output logic      [3:0]  payload_bytes
);

  // Register map, byte addressed, data in the low byte of the word:
  //   LEN_CTRL_OFFSET  length/control byte, read only
  //   STATUS_OFFSET    decoded length: valid flag and byte count
  //   anything else    reads as zero; every write is answered and dropped
  state_s st_ff;
  state_s nxt_st;
  logic   req;

  assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;

  // Next state: frame capture, length decode and bus answer
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = req;
    if (frame_load) begin
      nxt_st.remote_request_flag = frame_ctrl.remote_request_flag;
      nxt_st.payload_length_code = frame_ctrl.payload_length_code;
      // Codes above eight are reserved and report no valid length
      nxt_st.length_valid =
        (frame_ctrl.payload_length_code <= LEN_MAX);
      nxt_st.payload_bytes = (frame_ctrl.payload_length_code <= LEN_MAX)
        ? frame_ctrl.payload_length_code : 4'h0;
    end
    // Writes are acknowledged and ignored: the register is read only
    nxt_st.dat = UNMAPPED_DATA;
    if (req && !wb_we_i) begin
      if (wb_adr_i == LEN_CTRL_OFFSET) begin
        nxt_st.dat[UNIMPL_BIT] = 1'b0;
        nxt_st.dat[RTR_BIT]    = st_ff.remote_request_flag;
        nxt_st.dat[RSV_HI_BIT] = 1'b0;
        nxt_st.dat[RSV_LO_BIT] = 1'b0;
        nxt_st.dat[3:0]        = st_ff.payload_length_code;
      end else if (wb_adr_i == STATUS_OFFSET) begin
        nxt_st.dat[VALID_BIT] = st_ff.length_valid;
        nxt_st.dat[3:0]       = st_ff.payload_bytes;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{remote_request_flag: LEN_CTRL_RESET[RTR_BIT],
                 payload_length_code: LEN_CTRL_RESET[3:0],
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o      = st_ff.dat;
  assign wb_ack_o      = st_ff.ack;
  assign payload_valid = st_ff.length_valid;
  assign payload_bytes = st_ff.payload_bytes;

  // Checks on the stored fields, the decoded outputs and the bus answer.
  // Read data is registered, so a read check looks one cycle after the
  // request is taken; every check is idle while reset is high.

  // Bit 7 is unimplemented and never reads as one
  AST_BIT7_ZERO: assert property (
    @(posedge clk) disable iff (rst)
    wb_ack_o |-> wb_dat_o[UNIMPL_BIT] == 1'b0)
    else $error("bit 7 read as one");

  // A stored remote flag follows the frame that loaded it
  AST_RTR_LOAD: assert property (
    @(posedge clk) disable iff (rst)
    frame_load |=> st_ff.remote_request_flag ==
      $past(frame_ctrl.remote_request_flag))
    else $error("remote flag not loaded");

  // A read of the byte shows the stored remote flag in bit 6
  AST_RTR_READ: assert property (
    @(posedge clk) disable iff (rst)
    req && !wb_we_i && wb_adr_i == LEN_CTRL_OFFSET
    |=> wb_dat_o[RTR_BIT] == $past(st_ff.remote_request_flag))
    else $error("remote flag misread");

  // reserved_upper reads as zero from every address
  AST_RSV_HI: assert property (
    @(posedge clk) disable iff (rst)
    wb_ack_o |-> !wb_dat_o[RSV_HI_BIT])
    else $error("reserved_upper read as one");

  // reserved_lower reads as zero from the length byte
  AST_RSV_LO: assert property (
    @(posedge clk) disable iff (rst)
    wb_ack_o && $past(wb_adr_i) == LEN_CTRL_OFFSET
    |-> !wb_dat_o[RSV_LO_BIT])
    else $error("reserved_lower read as one");

  // The code bits of a read show the stored code
  AST_CODE_READ: assert property (
    @(posedge clk) disable iff (rst)
    req && !wb_we_i && wb_adr_i == LEN_CTRL_OFFSET && !frame_load
    |=> wb_dat_o[3:0] == st_ff.payload_length_code)
    else $error("length code misread");

  // The code is stored raw, reserved values included
  AST_CODE_STORE: assert property (
    @(posedge clk) disable iff (rst)
    frame_load |=> st_ff.payload_length_code ==
      $past(frame_ctrl.payload_length_code))
    else $error("length code not stored");

  // Without a new frame the stored fields hold still
  AST_FIELDS_HOLD: assert property (
    @(posedge clk) disable iff (rst)
    !frame_load |=> $stable(st_ff.remote_request_flag) &&
      $stable(st_ff.payload_length_code))
    else $error("stored fields changed without a frame");

  // A legal code gives its own value as the byte count
  AST_COUNT: assert property (
    @(posedge clk) disable iff (rst)
    frame_load && frame_ctrl.payload_length_code <= LEN_MAX
    |=> payload_valid &&
      payload_bytes == $past(frame_ctrl.payload_length_code))
    else $error("valid length not counted");

  // The byte count never exceeds the largest legal length
  AST_COUNT_RANGE: assert property (
    @(posedge clk) disable iff (rst)
    payload_bytes <= LEN_MAX)
    else $error("byte count above eight");

  // A valid length always matches the stored code
  AST_VALID_MATCH: assert property (
    @(posedge clk) disable iff (rst)
    payload_valid |-> payload_bytes == st_ff.payload_length_code &&
      st_ff.payload_length_code <= LEN_MAX)
    else $error("valid length differs from stored code");

  // Codes above eight report no length
  AST_RESERVED_CODE: assert property (
    @(posedge clk) disable iff (rst)
    frame_load && frame_ctrl.payload_length_code > LEN_MAX
    |=> !payload_valid && payload_bytes == 4'h0)
    else $error("reserved code taken as length");

  // Code zero is a valid frame with no payload
  AST_ZERO_LEN: assert property (
    @(posedge clk) disable iff (rst)
    frame_load && frame_ctrl.payload_length_code == 4'h0
    |=> payload_valid && payload_bytes == 4'h0)
    else $error("empty frame misreported");

  // The status word mirrors the decoded outputs
  AST_STATUS_READ: assert property (
    @(posedge clk) disable iff (rst)
    req && !wb_we_i && wb_adr_i == STATUS_OFFSET
    |=> wb_dat_o[VALID_BIT] == $past(payload_valid) &&
      wb_dat_o[3:0] == $past(payload_bytes))
    else $error("status word misread");

  // Each request taken is answered on the next cycle
  AST_ACK_NEXT: assert property (
    @(posedge clk) disable iff (rst)
    req |=> wb_ack_o)
    else $error("request not answered");

  // An answer always follows a taken request
  AST_ACK_CAUSE: assert property (
    @(posedge clk) disable iff (rst)
    wb_ack_o |-> $past(req))
    else $error("answer without request");

  // ack stands for exactly one cycle
  AST_ACK_ONE: assert property (
    @(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // Read data is zero outside the answer cycle
  AST_DAT_IDLE: assert property (
    @(posedge clk) disable iff (rst)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside answer");

  // Only the low byte of an answer ever carries data
  AST_UPPER_ZERO: assert property (
    @(posedge clk) disable iff (rst)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");

  // Writes are answered with zero data and change nothing
  AST_WRITE_QUIET: assert property (
    @(posedge clk) disable iff (rst)
    req && wb_we_i |=> wb_dat_o == '0)
    else $error("write answered with data");

  // Reads of unmapped addresses return zero
  AST_UNMAPPED: assert property (
    @(posedge clk) disable iff (rst)
    req && !wb_we_i && wb_adr_i != LEN_CTRL_OFFSET &&
      wb_adr_i != STATUS_OFFSET |=> wb_dat_o == UNMAPPED_DATA)
    else $error("unmapped read not zero");

  // Main scenarios
  COV_RTR: cover property (@(posedge clk) disable iff (rst)
    frame_load && frame_ctrl.remote_request_flag);
  COV_MAX: cover property (@(posedge clk) disable iff (rst)
    frame_load && frame_ctrl.payload_length_code == LEN_MAX);
  COV_RSV: cover property (@(posedge clk) disable iff (rst)
    frame_load && frame_ctrl.payload_length_code == 4'hF);
  COV_READ: cover property (@(posedge clk) disable iff (rst)
    wb_ack_o && !$past(wb_we_i));
  COV_WRITE: cover property (@(posedge clk) disable iff (rst)
    wb_ack_o && $past(wb_we_i));

endmodule : can_rx_length_control_field

// file: rx_len_pkg.sv
// Constants and types for the receive frame length/control status byte.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
package rx_len_pkg;
  localparam logic [7:0] LEN_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET   = 8'h04;
  localparam int         RTR_BIT         = 6;
  localparam int         RSV_HI_BIT      = 5;
  localparam int         RSV_LO_BIT      = 4;
  localparam int         UNIMPL_BIT      = 7;
  localparam int         VALID_BIT       = 4;
  localparam logic [3:0] LEN_MAX         = 4'h8;
  localparam logic [7:0] LEN_CTRL_RESET  = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;

  // Control field as handed over by the protocol engine
  typedef struct packed {
    logic       remote_request_flag;
    logic [3:0] payload_length_code;
  } ctrl_field_s;

  // Whole state of the register block
  typedef struct packed {
    logic        remote_request_flag;
    logic [3:0]  payload_length_code;
    logic        length_valid;
    logic [3:0]  payload_bytes;
    logic        ack;
    logic [31:0] dat;
  } state_s;
endpackage : rx_len_pkg
